// [rtl/cwst_consts.vh]
// Purpose: Constants for the channel window and steepness trigger
// Assumes: Register offsets are word indices on the plain register port
// Notes: Level and width reset values are neutral defaults
`ifndef CWST_CONSTS_VH
`define CWST_CONSTS_VH

// Register offsets
`define CWST_ADDR_MODE 16'h9ea2
`define CWST_ADDR_UPPER 16'ha4d8
`define CWST_ADDR_LOWER 16'ha53c
`define CWST_ADDR_WIDTH 16'hac45
`define CWST_ADDR_STATUS 16'hb000
`define CWST_ADDR_MASK 16'hb001
`define CWST_ADDR_STATE 16'hb002
`define CWST_ADDR_COUNT 16'hb003
`define CWST_ADDR_DIVIDER 16'hb004

// Mode codes
`define CWST_MODE_STEEP_FALL 32'h02001000
`define CWST_MODE_WIN_ENTRY 32'h00000020
`define CWST_MODE_WIN_EXIT 32'h00000040
`define CWST_MODE_LONG_INNER 32'h04000020
`define CWST_MODE_LONG_OUTER 32'h04000040
`define CWST_MODE_SHORT_INNER 32'h02000020
`define CWST_MODE_SHORT_OUTER 32'h02000040

// Status and mask field positions
`define CWST_ST_TRIG 0
`define CWST_ST_SUPP 1
`define CWST_ST_W 2

// State readback field positions
`define CWST_SR_INSIDE 0
`define CWST_SR_BUSY 1
`define CWST_SR_KNOWN 2

// Reset values
`define CWST_RST_MODE 32'h00000000
`define CWST_RST_UPPER 32'h00000000
`define CWST_RST_LOWER 32'h00000000
`define CWST_RST_WIDTH 32'h00000002
`define CWST_RST_DIVIDER 32'h00000000

// Timing: samples are taken every (divider + 1) clocks of 100 ns
`define CWST_CLK_PERIOD_NS 100

`endif

// [rtl/cwst_trigger.v]
// Purpose: Per-channel window and steepness trigger detector
// Assumes: Samples arrive from front-end logic on clk_in at 10 MHz
// Notes: Sample rate is clk_in divided by (divider register + 1)
`timescale 1ns/100ps
`include "cwst_consts.vh"

// Operation
// RULE_01: Evaluate every sample in every mode
// RULE_02: Steep mode: falling upper crossing starts counter
// RULE_03: Steep mode: counter expiry suppresses trigger
// RULE_04: Steep mode: lower crossing while counting triggers
// RULE_05: Entry mode: outside-to-inside move triggers
// RULE_06: Exit mode: inside-to-outside move triggers
// RULE_07: Software writes upper and lower levels
// RULE_08: Software keeps width within 2..65535
// RULE_09: Entry width modes start counter on entry
// RULE_10: Exit width modes start counter on exit
// RULE_11: Long inner: expiry inside triggers, exit cancels
// RULE_12: Long outer: expiry outside triggers, entry cancels
// RULE_13: Short inner: early exit triggers, expiry cancels
// RULE_14: Short outer: early entry triggers, expiry cancels
// RULE_15: Inside means lower <= sample <= upper
module cwst_trigger #(
  parameter SAMPLE_W = 8,
  parameter WIDTH_W = 16,
  parameter COUNT_W = 16
) (
  input wire clk_in,
  input wire srst_in,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire [15:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg trig_out,
  output reg sample_tick_out,
  output wire irq_out
);
  // Registers written by software, and the trigger event count
  reg [31:0] mode_sel;
  reg [SAMPLE_W-1:0] upper_level;
  reg [SAMPLE_W-1:0] lower_level;
  reg [WIDTH_W-1:0] width_samples;
  reg [15:0] divider;
  reg [`CWST_ST_W-1:0] irq_status;
  reg [`CWST_ST_W-1:0] irq_mask;
  reg [COUNT_W-1:0] trig_count;

  // Reset values, cut to the register widths below
  localparam [31:0] RST_UPPER = `CWST_RST_UPPER;
  localparam [31:0] RST_LOWER = `CWST_RST_LOWER;
  localparam [31:0] RST_DIVIDER = `CWST_RST_DIVIDER;

  // Sample-rate divider state
  reg [15:0] div_count;
  wire tick;

  // Zone classification of the current and previous sample
  wire now_inside;
  wire now_above;
  wire now_below;
  wire prev_inside;
  wire prev_above;
  wire prev_below;
  wire prev_valid;

  // Counter control
  reg cnt_start;
  reg cnt_stop;
  wire cnt_busy;
  wire cnt_expire;

  // Per-sample decisions
  reg next_trig;
  reg next_supp;
  wire mode_write;
  wire flush;
  wire entered;
  wire exited;
  wire fell_upper;
  wire fell_lower;
  wire known_mode;
  wire [`CWST_ST_W-1:0] events;
  wire [`CWST_ST_W-1:0] clear_bits;

  // True when the programmed mode equals the given code
  function is_mode;
    input [31:0] sel;
    input [31:0] code;
    begin
      is_mode = (sel == code);
    end
  endfunction

  // Width field of a 32-bit write, cut to the counter width
  function [WIDTH_W-1:0] width_field;
    input [31:0] value;
    begin
      width_field = value[WIDTH_W-1:0];
    end
  endfunction

  assign mode_write = wr_in && (addr_in == `CWST_ADDR_MODE);
  // A new mode starts from a clean history
  assign flush = mode_write;

  // RULE_01: continuous sample strobe
  always @(posedge clk_in) begin
    if (srst_in || div_count >= divider) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end
  assign tick = ~srst_in & (div_count >= divider);

  // Registered copy of the sample strobe for the outside world
  always @(posedge clk_in) begin
    if (srst_in) begin
      sample_tick_out <= 1'b0;
    end else begin
      sample_tick_out <= tick;
    end
  end

  // Window classifier
  cwst_zone #(
    .SAMPLE_W(SAMPLE_W)
  ) u_zone (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_in(tick),
    .flush_in(flush),
    .sample_in(sample_in),
    .upper_in(upper_level),
    .lower_in(lower_level),
    .now_inside_out(now_inside),
    .now_above_out(now_above),
    .now_below_out(now_below),
    .prev_inside_out(prev_inside),
    .prev_above_out(prev_above),
    .prev_below_out(prev_below),
    .prev_valid_out(prev_valid)
  );

  // Pulse-width counter
  cwst_width_counter #(
    .WIDTH_W(WIDTH_W)
  ) u_width (
    .clk_in(clk_in),
    .srst_in(srst_in | flush),
    .tick_in(tick),
    .start_in(cnt_start),
    .stop_in(cnt_stop),
    .width_in(width_samples),
    .busy_out(cnt_busy),
    .expire_out(cnt_expire)
  );

  // Crossings between the previous and the current sample
  assign entered = tick & prev_valid & ~prev_inside & now_inside;
  assign exited = tick & prev_valid & prev_inside & ~now_inside;
  assign fell_upper = tick & prev_valid & prev_above & ~now_above;
  assign fell_lower = tick & prev_valid & ~prev_below & now_below;

  assign known_mode = is_mode(mode_sel, `CWST_MODE_STEEP_FALL) |
                      is_mode(mode_sel, `CWST_MODE_WIN_ENTRY) |
                      is_mode(mode_sel, `CWST_MODE_WIN_EXIT) |
                      is_mode(mode_sel, `CWST_MODE_LONG_INNER) |
                      is_mode(mode_sel, `CWST_MODE_LONG_OUTER) |
                      is_mode(mode_sel, `CWST_MODE_SHORT_INNER) |
                      is_mode(mode_sel, `CWST_MODE_SHORT_OUTER);

  // Trigger decision for the current sample
  always @* begin
    next_trig = 1'b0;
    next_supp = 1'b0;
    cnt_start = 1'b0;
    cnt_stop = 1'b0;
    if (is_mode(mode_sel, `CWST_MODE_STEEP_FALL)) begin
      if (cnt_busy && !cnt_expire && fell_lower) begin
        // RULE_04: lower crossing in time
        next_trig = 1'b1;
        cnt_stop = 1'b1;
      end else if (cnt_expire) begin
        // RULE_03: too slow, suppressed
        next_supp = 1'b1;
      end
      // RULE_02: falling upper crossing
      if (fell_upper) begin
        cnt_start = 1'b1;
        if (fell_lower) begin
          next_trig = 1'b1;
          cnt_start = 1'b0;
          cnt_stop = 1'b1;
        end
      end
    end else if (is_mode(mode_sel, `CWST_MODE_WIN_ENTRY)) begin
      // RULE_05: entry event
      next_trig = entered;
    end else if (is_mode(mode_sel, `CWST_MODE_WIN_EXIT)) begin
      // RULE_06: exit event
      next_trig = exited;
    end else if (is_mode(mode_sel, `CWST_MODE_LONG_INNER)) begin
      // RULE_11: expiry while inside
      if (cnt_expire && now_inside) begin
        next_trig = 1'b1;
      end else if (cnt_busy && exited) begin
        next_supp = 1'b1;
        cnt_stop = 1'b1;
      end
      // RULE_09: start on each entry
      cnt_start = entered;
    end else if (is_mode(mode_sel, `CWST_MODE_LONG_OUTER)) begin
      // RULE_12: expiry while outside
      if (cnt_expire && !now_inside) begin
        next_trig = 1'b1;
      end else if (cnt_busy && entered) begin
        next_supp = 1'b1;
        cnt_stop = 1'b1;
      end
      // RULE_10: start on each exit
      cnt_start = exited;
    end else if (is_mode(mode_sel, `CWST_MODE_SHORT_INNER)) begin
      // RULE_13: early exit triggers
      if (cnt_busy && !cnt_expire && exited) begin
        next_trig = 1'b1;
        cnt_stop = 1'b1;
      end else if (cnt_expire) begin
        next_supp = 1'b1;
      end
      // RULE_09: start on each entry
      cnt_start = entered;
    end else if (is_mode(mode_sel, `CWST_MODE_SHORT_OUTER)) begin
      // RULE_14: early entry triggers
      if (cnt_busy && !cnt_expire && entered) begin
        next_trig = 1'b1;
        cnt_stop = 1'b1;
      end else if (cnt_expire) begin
        next_supp = 1'b1;
      end
      // RULE_10: start on each exit
      cnt_start = exited;
    end
  end

  // Registered trigger pulse
  always @(posedge clk_in) begin
    if (srst_in) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= next_trig;
    end
  end

  // Trigger event counter, wraps around
  always @(posedge clk_in) begin
    if (srst_in) begin
      trig_count <= {COUNT_W{1'b0}};
    end else if (next_trig) begin
      trig_count <= trig_count + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // RULE_07: level and width registers
  always @(posedge clk_in) begin
    if (srst_in) begin
      mode_sel <= `CWST_RST_MODE;
      upper_level <= RST_UPPER[SAMPLE_W-1:0];
      lower_level <= RST_LOWER[SAMPLE_W-1:0];
      width_samples <= width_field(`CWST_RST_WIDTH);
      divider <= RST_DIVIDER[15:0];
      irq_mask <= {`CWST_ST_W{1'b0}};
    end else if (wr_in) begin
      case (addr_in)
        `CWST_ADDR_MODE: begin
          mode_sel <= wdata_in;
        end
        `CWST_ADDR_UPPER: begin
          upper_level <= wdata_in[SAMPLE_W-1:0];
        end
        `CWST_ADDR_LOWER: begin
          lower_level <= wdata_in[SAMPLE_W-1:0];
        end
        // RULE_08: width taken as written, cut to WIDTH_W bits
        `CWST_ADDR_WIDTH: begin
          width_samples <= width_field(wdata_in);
        end
        `CWST_ADDR_DIVIDER: begin
          divider <= wdata_in[15:0];
        end
        `CWST_ADDR_MASK: begin
          irq_mask <= wdata_in[`CWST_ST_W-1:0];
        end
        default: begin
          mode_sel <= mode_sel;
        end
      endcase
    end
  end

  // Sticky event bits, a new event wins over a write-one clear
  assign events = {next_supp, next_trig};
  assign clear_bits = (wr_in && addr_in == `CWST_ADDR_STATUS) ? wdata_in[`CWST_ST_W-1:0] : {`CWST_ST_W{1'b0}};
  always @(posedge clk_in) begin
    if (srst_in) begin
      irq_status <= {`CWST_ST_W{1'b0}};
    end else begin
      irq_status <= (irq_status & ~clear_bits) | events;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq_out = |(irq_status & irq_mask);

  // Read data one cycle after the read strobe, zero elsewhere
  always @(posedge clk_in) begin
    if (srst_in || !rd_in) begin
      rdata_out <= 32'h00000000;
    end else begin
      case (addr_in)
        `CWST_ADDR_MODE: begin
          rdata_out <= mode_sel;
        end
        `CWST_ADDR_UPPER: begin
          rdata_out <= {{(32-SAMPLE_W){1'b0}}, upper_level};
        end
        `CWST_ADDR_LOWER: begin
          rdata_out <= {{(32-SAMPLE_W){1'b0}}, lower_level};
        end
        `CWST_ADDR_WIDTH: begin
          rdata_out <= {{(32-WIDTH_W){1'b0}}, width_samples};
        end
        `CWST_ADDR_STATUS: begin
          rdata_out <= {{(32-`CWST_ST_W){1'b0}}, irq_status};
        end
        `CWST_ADDR_MASK: begin
          rdata_out <= {{(32-`CWST_ST_W){1'b0}}, irq_mask};
        end
        `CWST_ADDR_STATE: begin
          rdata_out <= {29'h00000000, known_mode, cnt_busy, prev_inside};
        end
        `CWST_ADDR_COUNT: begin
          rdata_out <= {{(32-COUNT_W){1'b0}}, trig_count};
        end
        `CWST_ADDR_DIVIDER: begin
          rdata_out <= {16'h0000, divider};
        end
        default: begin
          rdata_out <= 32'h00000000;
        end
      endcase
    end
  end
endmodule

// [rtl/cwst_width_counter.v]
// Purpose: Pulse-width sample counter with start, stop and expiry
// Assumes: tick_in marks one sample; start wins over stop and expiry
// Notes: Expiry is reported in the sample where the count reaches width_in
`timescale 1ns/100ps
module cwst_width_counter #(
  parameter WIDTH_W = 16
) (
  input wire clk_in,
  input wire srst_in,
  input wire tick_in,
  input wire start_in,
  input wire stop_in,
  input wire [WIDTH_W-1:0] width_in,
  output reg busy_out,
  output wire expire_out
);
  reg [WIDTH_W-1:0] count;

  // Reaching the programmed count ends the measurement
  assign expire_out = tick_in & busy_out & (count >= width_in);

  // Count samples since the start sample, which counts as one
  always @(posedge clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
      count <= {WIDTH_W{1'b0}};
    end else if (tick_in) begin
      if (start_in) begin
        busy_out <= 1'b1;
        count <= {{(WIDTH_W-1){1'b0}}, 1'b1};
      end else if (stop_in || expire_out) begin
        busy_out <= 1'b0;
      end else if (busy_out) begin
        count <= count + {{(WIDTH_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [rtl/cwst_zone.v]
// Purpose: Classify each sample against the two levels and keep the last one
// Assumes: Unsigned sample and level codes on the same scale
// Notes: Previous-state outputs are valid only when prev_valid_out is high
`timescale 1ns/100ps
module cwst_zone #(
  parameter SAMPLE_W = 8
) (
  input wire clk_in,
  input wire srst_in,
  input wire tick_in,
  input wire flush_in,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire [SAMPLE_W-1:0] upper_in,
  input wire [SAMPLE_W-1:0] lower_in,
  output wire now_inside_out,
  output wire now_above_out,
  output wire now_below_out,
  output reg prev_inside_out,
  output reg prev_above_out,
  output reg prev_below_out,
  output reg prev_valid_out
);
  // RULE_15: inclusive window bounds
  assign now_above_out = (sample_in > upper_in);
  assign now_below_out = (sample_in < lower_in);
  assign now_inside_out = ~now_above_out & ~now_below_out;

  // Previous sample class, forgotten on flush
  always @(posedge clk_in) begin
    if (srst_in || flush_in) begin
      prev_inside_out <= 1'b0;
      prev_above_out <= 1'b0;
      prev_below_out <= 1'b0;
      prev_valid_out <= 1'b0;
    end else if (tick_in) begin
      prev_inside_out <= now_inside_out;
      prev_above_out <= now_above_out;
      prev_below_out <= now_below_out;
      prev_valid_out <= 1'b1;
    end
  end
endmodule

// [testbench/cwst_sample_src.sv]
// Purpose: Stand-in for the digitised channel samples
// Assumes: One sample per clock while the divider is zero
// Notes: The last sample stays on the line, as a converter would
`timescale 1ns/100ps
module cwst_sample_src (
  input wire clk_in,
  output logic [7:0] sample_out
);
  initial sample_out = 8'h0;
  // Present eight samples, first in the low byte
  task automatic play(input logic [63:0] seq);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      sample_out <= seq[8*i +: 8];
    end
  endtask
endmodule

// [testbench/cwst_trigger_bench.sv]
// Purpose: Self-checking bench for the window and steepness trigger
// Assumes: Levels 200 and 100, width 3, divider zero in the rows
// Notes: Trigger counts come from trig_out pulses
`timescale 1ns/100ps
`include "cwst_consts.vh"
module cwst_trigger_bench;
  typedef struct {
    logic [31:0] m;
    logic [63:0] s;
    logic [31:0] n;
  } cwst_row_t;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [15:0] addr_in = 16'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  wire [7:0] sample_w;
  wire [31:0] rdata_out;
  wire trig_out, sample_tick_out, irq_out;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] trig_total = 32'h0;
  logic [31:0] tick_total = 32'h0;
  logic [31:0] rv, base;
  logic [15:0] ra [9] = '{`CWST_ADDR_MODE, `CWST_ADDR_UPPER, `CWST_ADDR_LOWER, `CWST_ADDR_WIDTH,
    `CWST_ADDR_STATUS, `CWST_ADDR_MASK, `CWST_ADDR_COUNT, `CWST_ADDR_DIVIDER, 16'h0};
  // Mode, samples first in low byte, expected triggers
  cwst_row_t rows [9] = '{
    '{`CWST_MODE_WIN_ENTRY, 64'h969663c8c9966432, 32'h3},
    '{`CWST_MODE_WIN_EXIT, 64'h969663c8c9966432, 32'h2},
    '{`CWST_MODE_LONG_INNER, 64'h3296329696969632, 32'h1},
    '{`CWST_MODE_LONG_OUTER, 64'h9632963232323296, 32'h1},
    '{`CWST_MODE_SHORT_INNER, 64'h3232969696329632, 32'h1},
    '{`CWST_MODE_SHORT_OUTER, 64'h9696323232963296, 32'h1},
    '{`CWST_MODE_STEEP_FALL, 64'h32969696fa3296fa, 32'h1},
    '{`CWST_MODE_STEEP_FALL, 64'h32fa32fa32fa32fa, 32'h4},
    '{32'h0, 64'h969663c8c9966432, 32'h0}};
  cwst_trigger dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .sample_in(sample_w), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .trig_out(trig_out), .sample_tick_out(sample_tick_out), .irq_out(irq_out)
  );
  cwst_sample_src src_u (.clk_in(clk_in), .sample_out(sample_w));
  // Clock of 100 ns
  always #50 clk_in = ~clk_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Pulse counters and hang limit
  always @(posedge clk_in) begin
    if (trig_out === 1'b1) trig_total <= trig_total + 32'h1;
    if (sample_tick_out === 1'b1) tick_total <= tick_total + 32'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd_reg(ra[i], rv);
      check("reset value", rv, ra[i] == `CWST_ADDR_WIDTH ? 32'h2 : 32'h0);
    end
    $display("test reset values done");
    wr_reg(`CWST_ADDR_UPPER, 32'h1c8);
    wr_reg(`CWST_ADDR_LOWER, 32'h64);
    wr_reg(`CWST_ADDR_WIDTH, 32'h10003);
    rd_reg(`CWST_ADDR_UPPER, rv);
    check("upper level", rv, 32'hc8);
    rd_reg(`CWST_ADDR_WIDTH, rv);
    check("pulse width", rv, 32'h3);
    wr_reg(`CWST_ADDR_DIVIDER, 32'h1);
    repeat (2) @(posedge clk_in);
    base = tick_total;
    repeat (10) @(posedge clk_in);
    check("ticks at divider one", tick_total - base, 32'h5);
    wr_reg(`CWST_ADDR_DIVIDER, 32'h0);
    $display("test registers done");
    foreach (rows[i]) begin
      wr_reg(`CWST_ADDR_MODE, 32'h0);
      src_u.play({8{rows[i].s[7:0]}});
      wr_reg(`CWST_ADDR_MODE, rows[i].m);
      repeat (2) @(posedge clk_in);
      base = trig_total;
      src_u.play(rows[i].s);
      repeat (4) @(posedge clk_in);
      check("trigger count", trig_total - base, rows[i].n);
      $display("test row %0d done", i);
    end
    rd_reg(`CWST_ADDR_COUNT, rv);
    check("trigger total", rv, 32'he);
    rd_reg(`CWST_ADDR_STATE, rv);
    check("state idle", rv, 32'h1);
    wr_reg(`CWST_ADDR_MODE, `CWST_MODE_LONG_INNER);
    rd_reg(`CWST_ADDR_STATE, rv);
    check("state known mode", rv, 32'h5);
    rd_reg(`CWST_ADDR_STATUS, rv);
    check("status", rv, 32'h3);
    check("irq masked", {31'h0, irq_out}, 32'h0);
    wr_reg(`CWST_ADDR_MASK, 32'h1);
    #1 check("irq on", {31'h0, irq_out}, 32'h1);
    wr_reg(`CWST_ADDR_STATUS, 32'h1);
    #1 check("irq cleared", {31'h0, irq_out}, 32'h0);
    rd_reg(`CWST_ADDR_STATUS, rv);
    check("status after clear", rv, 32'h2);
    $display("test interrupt done");
    @(posedge clk_in) srst_in <= 1'b1;
    @(posedge clk_in) srst_in <= 1'b0;
    rd_reg(`CWST_ADDR_COUNT, rv);
    check("count after reset", rv, 32'h0);
    $display("test second reset done");
    report_and_stop;
  end
endmodule

// [testbench/cwst_trigger_props.sv]
// Purpose: Port-level checker for the window and steepness trigger
// Assumes: Levels and divider change only through bus writes
// Notes: Trigger checks for the seven modes apply while the divider is zero
`timescale 1ns/100ps
`include "cwst_consts.vh"
module cwst_trigger_props #(
  parameter SAMPLE_W = 8
) (
  input wire clk_in,
  input wire srst_in,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire [15:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire trig_out,
  input wire sample_tick_out,
  input wire irq_out
);
  logic [31:0] mode;
  logic [SAMPLE_W-1:0] up, lo, s1;
  logic w1, r1, dz, ip, ip2, lx;
  // History is valid: no recent write or reset
  wire ok = dz && !w1 && !r1;
  wire t = trig_out && dz && !w1;
  function automatic logic ins(input logic [SAMPLE_W-1:0] s);
    return s >= lo && s <= up;
  endfunction
  // Shadow registers and sample history
  always @(posedge clk_in) begin
    s1 <= sample_in;
    w1 <= wr_in;
    r1 <= srst_in;
    ip <= ins(sample_in);
    ip2 <= ip;
    lx <= s1 >= lo && sample_in < lo;
    if (srst_in) begin
      mode <= 32'h0;
      up <= '0;
      lo <= '0;
      dz <= 1'b1;
    end else if (wr_in) begin
      case (addr_in)
        `CWST_ADDR_MODE: mode <= wdata_in;
        `CWST_ADDR_UPPER: up <= wdata_in[SAMPLE_W-1:0];
        `CWST_ADDR_LOWER: lo <= wdata_in[SAMPLE_W-1:0];
        `CWST_ADDR_DIVIDER: dz <= wdata_in[15:0] == 16'h0;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  AST_ENTRY_TRIG: assert property (
    mode == `CWST_MODE_WIN_ENTRY && ok && !ins(s1) && ins(sample_in) |=> trig_out)
    else $error("window entry gave no trigger");
  AST_EXIT_TRIG: assert property (
    mode == `CWST_MODE_WIN_EXIT && ok && ins(s1) && !ins(sample_in) |=> trig_out)
    else $error("window exit gave no trigger");
  AST_STEEP_BOTH: assert property (
    mode == `CWST_MODE_STEEP_FALL && ok && s1 > up && sample_in < lo |=> trig_out)
    else $error("fall through both levels gave no trigger");
  AST_STEEP_LOWER: assert property (
    mode == `CWST_MODE_STEEP_FALL && t |-> lx)
    else $error("steep trigger without lower crossing");
  AST_LONG_IN: assert property (
    mode == `CWST_MODE_LONG_INNER && t |-> ip)
    else $error("long inner trigger with sample outside");
  AST_LONG_OUT: assert property (
    mode == `CWST_MODE_LONG_OUTER && t |-> !ip)
    else $error("long outer trigger with sample inside");
  AST_SHORT_IN: assert property (
    mode == `CWST_MODE_SHORT_INNER && t |-> ip2 && !ip)
    else $error("short inner trigger without exit");
  AST_SHORT_OUT: assert property (
    mode == `CWST_MODE_SHORT_OUTER && t |-> !ip2 && ip)
    else $error("short outer trigger without entry");
  AST_NO_MODE: assert property (
    mode == 32'h0 && !w1 |-> !trig_out)
    else $error("trigger with no mode set");
  AST_TRIG_TICK: assert property (
    trig_out |-> sample_tick_out)
    else $error("trigger outside a sample tick");
  AST_RDATA_IDLE: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read answer");
  cover property (mode == `CWST_MODE_WIN_ENTRY && trig_out);
  cover property (mode == `CWST_MODE_STEEP_FALL && trig_out);
  cover property ($rose(irq_out));
endmodule
bind cwst_trigger cwst_trigger_props #(.SAMPLE_W(SAMPLE_W)) chk_u (
  .clk_in(clk_in), .srst_in(srst_in), .sample_in(sample_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .trig_out(trig_out), .sample_tick_out(sample_tick_out), .irq_out(irq_out)
);
